// ### design/pdc_pkg.sv
package pdc_pkg;

   // Core clock and derived cycle counts
   localparam int CORE_CLK_MHZ   = 250;
   localparam int SWITCH_TIME_NS = 40;
   localparam int SWITCH_CYCLES  = (SWITCH_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int LOCK_TIME_NS   = 200;
   localparam int LOCK_CYCLES    = (LOCK_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

   // Register byte offsets
   localparam logic [3:0] OFS_CTRL     = 4'h0;
   localparam logic [3:0] OFS_MAIN_DIV = 4'h4;
   localparam logic [3:0] OFS_AUX_DIV  = 4'h8;
   localparam logic [3:0] OFS_STATUS   = 4'hc;

   // Control fields
   localparam int CTRL_SRC_LSB     = 0;
   localparam int CTRL_AUX_EN_BIT  = 2;
   localparam int CTRL_AUX_EXT_BIT = 3;

   // Divider fields
   localparam int DIV_PRE_LSB   = 0;
   localparam int DIV_FB_LSB    = 8;
   localparam int DIV_POST1_LSB = 16;
   localparam int DIV_POST2_LSB = 20;

   // Status fields
   localparam int ST_SRC_LSB    = 0;
   localparam int ST_BUSY_BIT   = 2;
   localparam int ST_MLOCK_BIT  = 3;
   localparam int ST_ARUN_BIT   = 4;
   localparam int ST_ALOCK_BIT  = 5;
   localparam int ST_REJECT_BIT = 6;

   typedef enum logic [1:0] {
      PDC_SRC_FAST_RC,
      PDC_SRC_EXT_OSC,
      PDC_SRC_FAST_RC_LOOP,
      PDC_SRC_EXT_OSC_LOOP
   } pdc_src_e;

   typedef enum logic {
      PDC_SW_IDLE,
      PDC_SW_BUSY
   } pdc_sw_e;

   typedef struct packed {
      logic [2:0] second_output_divider;
      logic [2:0] first_output_divider;
      logic [7:0] feedback_multiplier;
      logic [3:0] input_prescale_divider;
   } pdc_div_s;

   localparam pdc_div_s DIV_RESET = '{
      second_output_divider:  3'h1,
      first_output_divider:   3'h4,
      feedback_multiplier:    8'h64,
      input_prescale_divider: 4'h1
   };
   localparam pdc_src_e SRC_RESET = PDC_SRC_FAST_RC;

endpackage

// ### design/pdc_loop_unit.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_loop_unit
   import pdc_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_srst,
   input  wire pdc_div_s   i_cfg,
   input  wire logic       i_load_ok,
   input  wire logic       i_run,
   output pdc_div_s        o_active,
   output logic [9:0]      o_den,
   output logic            o_lock
);
   pdc_div_s   act_q, act_d;
   logic [9:0] den_q, den_d;
   logic [7:0] cnt_q, cnt_d;
   logic       lock_q, lock_d;

   always_comb begin
      act_d  = act_q;
      cnt_d  = cnt_q;
      lock_d = lock_q;
      if (i_load_ok) begin
         act_d = i_cfg;                                           // [RULE_16]
      end
      // Output ratio denominator: prescale times both output dividers
      den_d = 10'(act_d.input_prescale_divider * act_d.first_output_divider
                  * act_d.second_output_divider);                 // [RULE_06] [RULE_14]
      if (!i_run) begin
         cnt_d  = 8'h0;
         lock_d = 1'b0;
      end else if (cnt_q == 8'(LOCK_CYCLES - 1)) begin
         lock_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 8'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         act_q  <= DIV_RESET;
         den_q  <= 10'h4;
         cnt_q  <= 8'h0;
         lock_q <= 1'b0;
      end else begin
         act_q  <= act_d;
         den_q  <= den_d;
         cnt_q  <= cnt_d;
         lock_q <= lock_d;
      end
   end

   assign o_active = act_q;
   assign o_den    = den_q;
   assign o_lock   = lock_q;

   AST_LOOP_HOLD: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_16]
      !i_load_ok |=> $stable(act_q))
      else $error("divider setting changed while loop in use");
   AST_LOOP_DEN: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_06]
      $past(!i_srst) |-> o_den == 10'(act_q.input_prescale_divider
         * act_q.first_output_divider * act_q.second_output_divider))
      else $error("ratio denominator mismatch");
   AST_LOOP_LOCK: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_05]
      $rose(i_run) |-> !o_lock [*8])
      else $error("lock reported too early");
endmodule
`default_nettype wire

// ### design/pdc_top.sv
// Contract
// [RULE_01] Fast RC or external osc feeds main loop
// [RULE_02] Main loop reference kept 8 to 64 MHz
// [RULE_03] Phase compare input 8 MHz to VCO/16
// [RULE_04] Main VCO kept 400 to 1600 MHz
// [RULE_05] Main VCO equals input times multiplier over prescale
// [RULE_06] Main output divided by two cascaded dividers
// [RULE_07] Software reconfigures only from non-loop source
// [RULE_08] No direct loop-to-loop clock switch
// [RULE_09] Auxiliary loop independent of system clock source
// [RULE_10] Auxiliary reference kept 8 to 64 MHz
// [RULE_11] Auxiliary phase compare 8 MHz to VCO/16
// [RULE_12] Auxiliary VCO kept 400 to 1600 MHz
// [RULE_13] Auxiliary VCO from own multiplier and prescale
// [RULE_14] Auxiliary output divided by two cascaded dividers
// [RULE_15] Auxiliary loop waits for peripheral clock request
// [RULE_16] Settings apply only when loop not selected
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pdc_top
   import pdc_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_periph_clk_req,
   output pdc_src_e         o_sys_src,
   output logic             o_main_ref_ext,
   output pdc_div_s         o_main_cfg,
   output logic [9:0]       o_main_den,
   output logic             o_main_lock,
   output logic             o_aux_ref_ext,
   output logic             o_aux_run,
   output pdc_div_s         o_aux_cfg,
   output logic [9:0]       o_aux_den,
   output logic             o_aux_lock
);
   function automatic logic is_loop(input pdc_src_e s);
      is_loop = (s == PDC_SRC_FAST_RC_LOOP) || (s == PDC_SRC_EXT_OSC_LOOP);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   // Bus and register state
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   pdc_div_s    mshadow_q, mshadow_d, ashadow_q, ashadow_d;
   logic        aux_en_q, aux_en_d, aux_ext_q, aux_ext_d;
   logic        reject_q, reject_d;
   // Clock switch state
   pdc_sw_e     sw_q, sw_d;
   pdc_src_e    cur_q, cur_d, tgt_q, tgt_d;
   logic [7:0]  cnt_q, cnt_d;
   logic        ref_ext_q, ref_ext_d;
   // Auxiliary run state
   logic        req_s1_q, req_s2_q;
   logic        arun_q, arun_d;

   logic        wr_go, rd_go;
   logic [31:0] wmerge;
   pdc_src_e    wsrc;
   logic        main_load_ok, main_run;
   pdc_div_s    main_act, aux_act;
   logic [9:0]  main_den, aux_den;
   logic        main_lock, aux_lock;

   assign wr_go = i_avs_write && !wait_q;
   assign rd_go = i_avs_read && wait_q;

   always_comb begin
      wait_d    = 1'b1;
      rdata_d   = rdata_q;
      mshadow_d = mshadow_q;
      ashadow_d = ashadow_q;
      aux_en_d  = aux_en_q;
      aux_ext_d = aux_ext_q;
      reject_d  = reject_q;
      sw_d      = sw_q;
      cur_d     = cur_q;
      tgt_d     = tgt_q;
      cnt_d     = cnt_q;
      ref_ext_d = ref_ext_q;
      wmerge    = 32'h0;
      wsrc      = cur_q;
      if ((i_avs_read || i_avs_write) && wait_q) begin
         wait_d = 1'b0;
      end
      if (rd_go) begin
         case (i_avs_address)
            OFS_CTRL: begin
               rdata_d = 32'h0;
               rdata_d[CTRL_SRC_LSB +: 2]  = tgt_q;
               rdata_d[CTRL_AUX_EN_BIT]    = aux_en_q;
               rdata_d[CTRL_AUX_EXT_BIT]   = aux_ext_q;
            end
            OFS_MAIN_DIV: rdata_d = {9'h0, mshadow_q.second_output_divider, 1'b0,
                                     mshadow_q.first_output_divider,
                                     mshadow_q.feedback_multiplier, 4'h0,
                                     mshadow_q.input_prescale_divider};
            OFS_AUX_DIV:  rdata_d = {9'h0, ashadow_q.second_output_divider, 1'b0,
                                     ashadow_q.first_output_divider,
                                     ashadow_q.feedback_multiplier, 4'h0,
                                     ashadow_q.input_prescale_divider};
            OFS_STATUS: begin
               rdata_d = 32'h0;
               rdata_d[ST_SRC_LSB +: 2] = cur_q;
               rdata_d[ST_BUSY_BIT]     = (sw_q == PDC_SW_BUSY);
               rdata_d[ST_MLOCK_BIT]    = main_lock;
               rdata_d[ST_ARUN_BIT]     = arun_q;
               rdata_d[ST_ALOCK_BIT]    = aux_lock;
               rdata_d[ST_REJECT_BIT]   = reject_q;
            end
            default: rdata_d = 32'h0;
         endcase
      end
      if (wr_go) begin
         case (i_avs_address)
            OFS_MAIN_DIV: begin
               wmerge    = merge({8'h0, 1'b0, mshadow_q.second_output_divider, 1'b0,
                                  mshadow_q.first_output_divider,
                                  mshadow_q.feedback_multiplier, 4'h0,
                                  mshadow_q.input_prescale_divider},
                                 i_avs_writedata, i_avs_byteenable);
               mshadow_d = {wmerge[DIV_POST2_LSB +: 3], wmerge[DIV_POST1_LSB +: 3],
                            wmerge[DIV_FB_LSB +: 8], wmerge[DIV_PRE_LSB +: 4]};
            end
            OFS_AUX_DIV: begin
               wmerge    = merge({8'h0, 1'b0, ashadow_q.second_output_divider, 1'b0,
                                  ashadow_q.first_output_divider,
                                  ashadow_q.feedback_multiplier, 4'h0,
                                  ashadow_q.input_prescale_divider},
                                 i_avs_writedata, i_avs_byteenable);
               ashadow_d = {wmerge[DIV_POST2_LSB +: 3], wmerge[DIV_POST1_LSB +: 3],
                            wmerge[DIV_FB_LSB +: 8], wmerge[DIV_PRE_LSB +: 4]};
            end
            OFS_CTRL: begin
               if (i_avs_byteenable[0]) begin
                  aux_en_d  = i_avs_writedata[CTRL_AUX_EN_BIT];
                  aux_ext_d = i_avs_writedata[CTRL_AUX_EXT_BIT];
                  wsrc      = pdc_src_e'(i_avs_writedata[CTRL_SRC_LSB +: 2]);
               end
            end
            OFS_STATUS: begin
               if (i_avs_byteenable[0] && i_avs_writedata[ST_REJECT_BIT]) begin
                  reject_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      case (sw_q)
         PDC_SW_IDLE: begin
            if (wsrc != cur_q) begin
               if (is_loop(wsrc) && is_loop(cur_q)) begin
                  reject_d = 1'b1;                                // [RULE_08]
               end else begin
                  sw_d  = PDC_SW_BUSY;
                  tgt_d = wsrc;
                  cnt_d = 8'h0;
                  if (is_loop(wsrc)) begin
                     ref_ext_d = (wsrc == PDC_SRC_EXT_OSC_LOOP);  // [RULE_01]
                  end
               end
            end
         end
         PDC_SW_BUSY: begin
            if (cnt_q == 8'(SWITCH_CYCLES - 1)) begin
               sw_d  = PDC_SW_IDLE;
               cur_d = tgt_q;
            end else begin
               cnt_d = cnt_q + 8'h1;
            end
         end
         default: sw_d = PDC_SW_IDLE;
      endcase
      // Auxiliary loop runs on its own enable and a peripheral request only
      arun_d = aux_en_q && req_s2_q;                              // [RULE_09] [RULE_15]
   end

   // Main settings load only while no loop source is selected or being entered
   assign main_load_ok = !is_loop(cur_q) && !(sw_q == PDC_SW_BUSY && is_loop(tgt_q)); // [RULE_16]
   assign main_run     = is_loop(cur_q) || (sw_q == PDC_SW_BUSY && is_loop(tgt_q));

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         wait_q    <= 1'b1;
         rdata_q   <= 32'h0;
         mshadow_q <= DIV_RESET;
         ashadow_q <= DIV_RESET;
         aux_en_q  <= 1'b0;
         aux_ext_q <= 1'b0;
         reject_q  <= 1'b0;
         sw_q      <= PDC_SW_IDLE;
         cur_q     <= SRC_RESET;
         tgt_q     <= SRC_RESET;
         cnt_q     <= 8'h0;
         ref_ext_q <= 1'b0;
         req_s1_q  <= 1'b0;
         req_s2_q  <= 1'b0;
         arun_q    <= 1'b0;
      end else begin
         wait_q    <= wait_d;
         rdata_q   <= rdata_d;
         mshadow_q <= mshadow_d;
         ashadow_q <= ashadow_d;
         aux_en_q  <= aux_en_d;
         aux_ext_q <= aux_ext_d;
         reject_q  <= reject_d;
         sw_q      <= sw_d;
         cur_q     <= cur_d;
         tgt_q     <= tgt_d;
         cnt_q     <= cnt_d;
         ref_ext_q <= ref_ext_d;
         req_s1_q  <= i_periph_clk_req;
         req_s2_q  <= req_s1_q;
         arun_q    <= arun_d;
      end
   end

   pdc_loop_unit u_main_loop (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_cfg      (mshadow_q),
      .i_load_ok  (main_load_ok),
      .i_run      (main_run),
      .o_active   (main_act),
      .o_den      (main_den),
      .o_lock     (main_lock)
   );

   pdc_loop_unit u_aux_loop (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_cfg      (ashadow_q),
      .i_load_ok  (!arun_q),
      .i_run      (arun_q),
      .o_active   (aux_act),
      .o_den      (aux_den),
      .o_lock     (aux_lock)
   );

   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_sys_src         = cur_q;
   assign o_main_ref_ext    = ref_ext_q;
   assign o_main_cfg        = main_act;                           // [RULE_05]
   assign o_main_den        = main_den;
   assign o_main_lock       = main_lock;
   assign o_aux_ref_ext     = aux_ext_q;
   assign o_aux_run         = arun_q;
   assign o_aux_cfg         = aux_act;                            // [RULE_13]
   assign o_aux_den         = aux_den;
   assign o_aux_lock        = aux_lock;

   AST_NO_LOOP_TO_LOOP: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_08]
      (sw_q == PDC_SW_BUSY) |-> !(is_loop(cur_q) && is_loop(tgt_q)))
      else $error("direct loop to loop switch");
   AST_AUX_STOP: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_15]
      !(aux_en_q && req_s2_q) |=> !o_aux_run)
      else $error("auxiliary loop ran without request");
   AST_AUX_INDEP: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_09]
      (aux_en_q && req_s2_q) |=> o_aux_run)
      else $error("auxiliary loop blocked");
   AST_REF_SEL: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_01]
      (sw_q == PDC_SW_IDLE && is_loop(cur_q))
      |-> o_main_ref_ext == (cur_q == PDC_SRC_EXT_OSC_LOOP))
      else $error("main loop reference mismatch");
   AST_MAIN_RATIO: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_05]
      (is_loop(cur_q) && $stable(cur_q)) |-> $stable(o_main_cfg))
      else $error("main multiplier changed in loop mode");
   AST_AUX_HOLD: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_14]
      (o_aux_run && $past(o_aux_run)) |-> $stable(o_aux_cfg))
      else $error("auxiliary divider changed while running");
   AST_SWITCH_LEN: assert property (@(posedge i_core_clk) disable iff (i_srst) // [RULE_16]
      $rose(sw_q == PDC_SW_BUSY) |-> (sw_q == PDC_SW_BUSY) [*5] ##1
      (sw_q == PDC_SW_BUSY) [*5] ##1 (sw_q == PDC_SW_IDLE))
      else $error("clock switch length wrong");
   AST_WAIT_PULSE: assert property (@(posedge i_core_clk) disable iff (i_srst)
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low longer than one cycle");

   COV_SWITCH_LOOP: cover property (@(posedge i_core_clk) disable iff (i_srst)
      $rose(is_loop(cur_q)));
   COV_REJECT: cover property (@(posedge i_core_clk) disable iff (i_srst) $rose(reject_q));
   COV_AUX_LOCK: cover property (@(posedge i_core_clk) disable iff (i_srst) $rose(aux_lock));
endmodule
`default_nettype wire

// ### tb/pdc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_top_test;
   import pdc_pkg::*;

   typedef struct packed {
      logic [3:0] pre;
      logic [7:0] mult;
      logic [2:0] post1;
      logic [2:0] post2;
      logic [9:0] den;
   } pdc_row_s;

   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read    = 1'b0;
   logic        avs_write   = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        periph_req  = 1'b0;
   logic [31:0] o_avs_readdata;
   logic        o_avs_waitrequest;
   pdc_src_e    o_sys_src;
   logic        o_main_ref_ext;
   pdc_div_s    o_main_cfg;
   logic [9:0]  o_main_den;
   logic        o_main_lock;
   logic        o_aux_ref_ext;
   logic        o_aux_run;
   pdc_div_s    o_aux_cfg;
   logic [9:0]  o_aux_den;
   logic        o_aux_lock;
   int          n_errors = 0;
   int          comparisons = 0;
   logic [31:0] rd;
   pdc_div_s    held;

   // Rows stay legal for a reference of 8, 64, 16 and 32 MHz in turn
   pdc_row_s rows [4] = '{
      '{4'h1, 8'h7d, 3'h5, 3'h1, 10'h005},
      '{4'h8, 8'hc8, 3'h7, 3'h7, 10'h188},
      '{4'h2, 8'h64, 3'h3, 3'h2, 10'h00c},
      '{4'h4, 8'h32, 3'h2, 3'h1, 10'h008}
   };

   always #2 core_clk = ~core_clk;

   pdc_top dut (
      .i_core_clk        (core_clk),
      .i_srst            (srst),
      .i_avs_address     (avs_address),
      .i_avs_read        (avs_read),
      .i_avs_write       (avs_write),
      .i_avs_writedata   (avs_writedata),
      .i_avs_byteenable  (avs_byteenable),
      .o_avs_readdata    (o_avs_readdata),
      .o_avs_waitrequest (o_avs_waitrequest),
      .i_periph_clk_req  (periph_req),
      .o_sys_src         (o_sys_src),
      .o_main_ref_ext    (o_main_ref_ext),
      .o_main_cfg        (o_main_cfg),
      .o_main_den        (o_main_den),
      .o_main_lock       (o_main_lock),
      .o_aux_ref_ext     (o_aux_ref_ext),
      .o_aux_run         (o_aux_run),
      .o_aux_cfg         (o_aux_cfg),
      .o_aux_den         (o_aux_den),
      .o_aux_lock        (o_aux_lock)
   );

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] data);
      int n;
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk("waitrequest timeout", 32'h1, 32'h0);
      data = o_avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wait_src(input pdc_src_e s);
      for (int n = 0; n < 40 && o_sys_src !== s; n++) @(posedge core_clk);
   endtask

   function automatic logic [31:0] word(input pdc_row_s r);
      return {9'h0, r.post2, 1'b0, r.post1, r.mult, 4'h0, r.pre};
   endfunction

   function automatic pdc_div_s cfg(input pdc_row_s r);
      return '{second_output_divider: r.post2, first_output_divider: r.post1,
               feedback_multiplier: r.mult, input_prescale_divider: r.pre};
   endfunction

   task automatic chk_reset;
      chk("waitrequest", o_avs_waitrequest, 32'h1);
      chk("readdata", o_avs_readdata, 32'h0);
      chk("sys_src", o_sys_src, SRC_RESET);
      chk("main_cfg", o_main_cfg, DIV_RESET);
      chk("main_den", o_main_den, 32'h4);
      chk("aux_cfg", o_aux_cfg, DIV_RESET);
      chk("aux_den", o_aux_den, 32'h4);
      chk("flags", {o_main_lock, o_aux_run, o_aux_lock, o_main_ref_ext, o_aux_ref_ext}, 32'h0);
   endtask

   initial begin
      #(20000 * 4);
      n_errors++;
      wrap_up();
   end

   initial begin
      cyc(10);
      srst <= 1'b0;
      cyc(1);
      chk_reset();
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status reset", rd, 32'h0);
      bus(1'b0, 4'h2, 32'h0, rd);
      chk("unmapped read", rd, 32'h0);
      // Divider settings load while no loop source is selected
      foreach (rows[i]) begin
         bus(1'b1, OFS_MAIN_DIV, word(rows[i]), rd);
         bus(1'b1, OFS_AUX_DIV, word(rows[i]), rd);
         bus(1'b1, 4'h2, 32'hffffffff, rd);
         cyc(4);
         chk("main_cfg", o_main_cfg, cfg(rows[i]));
         chk("main_den", o_main_den, rows[i].den);
         chk("aux_cfg", o_aux_cfg, cfg(rows[i]));
         chk("aux_den", o_aux_den, rows[i].den);
         bus(1'b0, OFS_MAIN_DIV, 32'h0, rd);
         chk("main_div readback", rd, word(rows[i]));
      end
      // Byte enables: only the multiplier byte is written
      avs_byteenable <= 4'h2;
      bus(1'b1, OFS_MAIN_DIV, 32'hffff55ff, rd);
      avs_byteenable <= 4'hf;
      bus(1'b0, OFS_MAIN_DIV, 32'h0, rd);
      chk("byte enable readback", rd, 32'h00125504);
      // Switch to fast RC through the main loop
      held = o_main_cfg;
      bus(1'b1, OFS_CTRL, 32'h2, rd);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status busy", rd[ST_BUSY_BIT], 32'h1);
      wait_src(PDC_SRC_FAST_RC_LOOP);
      chk("sys_src", o_sys_src, PDC_SRC_FAST_RC_LOOP);
      chk("main_ref_ext", o_main_ref_ext, 32'h0);
      cyc(20);
      chk("main_lock early", o_main_lock, 32'h0);
      for (int n = 0; n < 100 && o_main_lock !== 1'b1; n++) @(posedge core_clk);
      chk("main_lock", o_main_lock, 32'h1);
      // New settings wait while the loop is selected
      bus(1'b1, OFS_MAIN_DIV, word(rows[1]), rd);
      cyc(20);
      chk("main_cfg held", o_main_cfg, held);
      // Loop to loop switch is refused and flagged
      bus(1'b1, OFS_CTRL, 32'h3, rd);
      cyc(15);
      chk("sys_src kept", o_sys_src, PDC_SRC_FAST_RC_LOOP);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("reject flag", rd[ST_REJECT_BIT], 32'h1);
      bus(1'b1, OFS_STATUS, 32'h40, rd);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("reject cleared", rd[ST_REJECT_BIT], 32'h0);
      // Second source write during a busy switch is ignored
      bus(1'b1, OFS_CTRL, 32'h1, rd);
      bus(1'b1, OFS_CTRL, 32'h0, rd);
      wait_src(PDC_SRC_EXT_OSC);
      cyc(15);
      chk("sys_src ext", o_sys_src, PDC_SRC_EXT_OSC);
      chk("main_cfg applied", o_main_cfg, cfg(rows[1]));
      // External osc through the loop, auxiliary loop enabled without request
      bus(1'b1, OFS_CTRL, 32'hf, rd);
      wait_src(PDC_SRC_EXT_OSC_LOOP);
      chk("main_ref_ext", o_main_ref_ext, 32'h1);
      chk("aux_ref_ext", o_aux_ref_ext, 32'h1);
      cyc(10);
      chk("aux_run idle", o_aux_run, 32'h0);
      held = o_aux_cfg;
      periph_req <= 1'b1;
      cyc(1);
      chk("aux_run early", o_aux_run, 32'h0);
      cyc(5);
      chk("aux_run", o_aux_run, 32'h1);
      chk("sys_src indep", o_sys_src, PDC_SRC_EXT_OSC_LOOP);
      for (int n = 0; n < 100 && o_aux_lock !== 1'b1; n++) @(posedge core_clk);
      chk("aux_lock", o_aux_lock, 32'h1);
      bus(1'b1, OFS_AUX_DIV, word(rows[2]), rd);
      cyc(10);
      chk("aux_cfg held", o_aux_cfg, held);
      periph_req <= 1'b0;
      cyc(8);
      chk("aux_run off", {o_aux_run, o_aux_lock}, 32'h0);
      chk("aux_cfg applied", o_aux_cfg, cfg(rows[2]));
      chk("aux_den", o_aux_den, rows[2].den);
      // Reset in mid-run
      srst <= 1'b1;
      cyc(2);
      srst <= 1'b0;
      cyc(1);
      chk_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
